// ### src/lock_mask_defines.svh
// constants for the feature lock mask and network identity bank
// assumes inclusion by bare name from the design files only
`ifndef LOCK_MASK_DEFINES_SVH
`define LOCK_MASK_DEFINES_SVH

// mask layout: 16 bits wide, 10 low bits carry a function
`define MASK_WIDTH        16
`define MASK_USED         10
`define MASK_RESET        16'h0040
// bit positions
`define BIT_KEY_MODE      0
`define BIT_KEY_DOWN      1
`define BIT_KEY_UP        2
`define BIT_KEY_FAN       3
`define BIT_KEY_POWER     4
`define BIT_KEY_SET       5
`define BIT_CONTACT_OFF   6
`define BIT_DOOR_UNUSED   7
`define BIT_COMM_LOCK     8
`define BIT_REMOTE_DOUT   9
`define KEY_COUNT         6

// identity layout and defaults
`define INST_WIDTH        22
`define HIGH_WIDTH        13
`define LOW_WIDTH         10
`define INST_MULT         13'h03E8
`define INST_RESET        22'h0927C1
`define HIGH_RESET        13'h0258
`define LOW_RESET         10'h001
`define UDP_RESET         16'hBAC0
`define HW_TAIL_RESET     16'h0000
`define BAUD_RESET        8'h00

`endif

// ### src/lock_mask_pkg.sv
// types shared by the lock mask bank and its bench
// assumes lock_mask_defines.svh sits beside it
`include "lock_mask_defines.svh"

package lock_mask_pkg;

  // which setting a configuration write targets
  typedef enum logic [2:0] {
    SEL_LOCK_MASK,
    SEL_INST_HIGH,
    SEL_INST_LOW,
    SEL_INSTANCE,
    SEL_UDP_PORT,
    SEL_HW_TAIL,
    SEL_BAUD
  } cfg_sel_t;

  // one configuration write from menu or network
  typedef struct packed {
    logic        valid;
    cfg_sel_t    sel;
    logic [31:0] data;
  } cfg_write_t;

  // occupancy command from the network supervisor
  typedef struct packed {
    logic valid;
    logic value;
  } occ_cmd_t;

endpackage

// ### src/instance_composer.sv
// composes the device instance from high and low menu parts
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/1ns
`default_nettype none
`include "lock_mask_defines.svh"

module instance_composer #(
  parameter int HIGH_W = `HIGH_WIDTH,
  parameter int LOW_W  = `LOW_WIDTH,
  parameter int INST_W = `INST_WIDTH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // request
  input  wire logic              start,
  input  wire logic [HIGH_W-1:0] high_part,
  input  wire logic [LOW_W-1:0]  low_part,
  // result, one cycle after start
  output var  logic              done_q,
  output var  logic [INST_W-1:0] result_q
);

  // high times one thousand plus low
  function automatic logic [INST_W-1:0] compose(input logic [HIGH_W-1:0] h, input logic [LOW_W-1:0] l);
    logic [INST_W-1:0] prod;
    // widen before the product, else it is cut to the high part's width
    prod = INST_W'(h) * INST_W'(`INST_MULT);
    return prod + INST_W'(l);
  endfunction

  // registered product keeps the multiplier off the output path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_q   <= 1'b0;
      result_q <= `INST_RESET;
    end else begin
      done_q <= start;
      if (start) begin
        result_q <= compose(high_part, low_part);
      end
    end
  end

endmodule // instance_composer
`default_nettype wire

// ### src/feature_lock_bank.sv
// Function
// - sixteen-bit mask, ten low bits functional
// - set bit locks, clear bit unlocks
// - bits zero to five gate panel keys
// - bit six set: occupancy from network/set
// - bit six clear: contact input drives occupancy
// - bit seven has no effect
// - bit eight refuses communication parameter changes
// - bit nine: outputs from algorithm or network
// - instance equals high times thousand plus low
// - network instance write, subject to lock
// - reset instance 600001, udp port 47808
//
// feature lock mask bank with network identity settings
// assumes key and contact pins are asynchronous, all else on clk
`timescale 1ns/1ns
`default_nettype none
`include "lock_mask_defines.svh"

module feature_lock_bank #(
  parameter int DOUT_W = 4 // number of digital outputs
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // configuration writes
  input  wire lock_mask_pkg::cfg_write_t   menu_write,
  input  wire lock_mask_pkg::cfg_write_t   net_write,
  // front panel and contact pins
  input  wire logic [`KEY_COUNT-1:0]       key_pins,
  input  wire logic                        occupancy_contact,
  // occupancy command from network
  input  wire lock_mask_pkg::occ_cmd_t     net_occupancy,
  // digital output sources
  input  wire logic [DOUT_W-1:0]           algo_outputs,
  input  wire logic [DOUT_W-1:0]           remote_outputs,
  // lock mask and key events
  output var  logic [`MASK_WIDTH-1:0]      feature_lock_mask_q,
  output var  logic [`KEY_COUNT-1:0]       key_press_q,
  // occupancy and outputs
  output var  logic                        occupancy_cmd_q,
  output var  logic [DOUT_W-1:0]           digital_outputs_q,
  // identity settings
  output var  logic [`INST_WIDTH-1:0]      device_instance_q,
  output var  logic [`HIGH_WIDTH-1:0]      instance_high_part_q,
  output var  logic [`LOW_WIDTH-1:0]       instance_low_part_q,
  output var  logic [15:0]                 udp_port_setting_q,
  output var  logic [15:0]                 hw_address_tail_q,
  output var  logic [7:0]                  baud_setting_q,
  // refused write indication
  output var  logic                        write_refused_q
);

  // behaviour notes for the next engineer
  //
  // configuration path
  // - one write slot per cycle, network first
  // - a menu write in the same cycle is dropped
  // - lock mask writes are never guarded
  // - every other setting obeys the comm lock
  // - udp port counted as a comm parameter
  // - refused writes pulse write_refused_q once
  //
  // instance path
  // - high or low write starts the composer
  // - part registers move one cycle after the write
  // - composed instance lands one cycle later
  // - direct instance write wins over a result
  // - direct write leaves high and low untouched
  // - high part not range limited here
  // - oversize products wrap to instance width
  //
  // panel and contact path
  // - all pins pass two flops first
  // - keys give one pulse per rising edge
  // - locked keys give no pulse at all
  // - unlocking mid press gives no late pulse
  //   once the edge has already passed
  // - contact lags its pin by three edges
  //
  // occupancy source
  // - bit six clear: contact level drives it
  // - bit six set: network command or set key
  // - network command beats a set press
  // - set press toggles, so bounce must be
  //   filtered before the pin
  //
  // output source
  // - bit nine picks remote over algorithm
  // - switch takes effect one cycle later
  // - no glitch filter on the source switch
  //
  // trade-offs
  // - composer registered to keep the
  //   multiplier off the write path
  // - costs one extra cycle of instance latency
  // - reserved mask bits cleared at write time
  //   so reads never need a mask

  // true for settings guarded by the communication lock
  function automatic logic is_comm_param(input lock_mask_pkg::cfg_sel_t sel);
    return (sel != lock_mask_pkg::SEL_LOCK_MASK);
  endfunction

  // accepted when valid and either unguarded or unlocked
  function automatic logic accept(input lock_mask_pkg::cfg_write_t w, input logic locked);
    return w.valid && !(locked && is_comm_param(w.sel));
  endfunction

  // network write wins over the menu when both arrive together
  lock_mask_pkg::cfg_write_t cfg_w;                  // selected write
  logic                      comm_locked;            // bit eight state
  logic                      cfg_ok;                 // write accepted
  logic                      compose_start;          // high or low written
  logic                      compose_done;           // composer result ready
  logic [`INST_WIDTH-1:0]    compose_result;         // composed instance
  logic [`HIGH_WIDTH-1:0]    high_d;                 // next high part
  logic [`LOW_WIDTH-1:0]     low_d;                  // next low part

  // synchroniser stages for asynchronous pins
  logic [`KEY_COUNT-1:0]     key_meta_q;             // first stage, keys
  logic [`KEY_COUNT-1:0]     key_sync_q;             // second stage, keys
  logic [`KEY_COUNT-1:0]     key_prev_q;             // last level for edges
  logic                      contact_meta_q;         // first stage, contact
  logic                      contact_sync_q;         // second stage, contact
  logic [`KEY_COUNT-1:0]     key_rise;               // new key presses
  logic                      set_press;              // unlocked set key press

  // write selection
  always_comb begin
    cfg_w = net_write.valid ? net_write : menu_write;
    comm_locked = feature_lock_mask_q[`BIT_COMM_LOCK];
    cfg_ok = accept(cfg_w, comm_locked);
  end

  // lock mask register; lock mask itself is never guarded
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      feature_lock_mask_q <= `MASK_RESET;
    end else if (cfg_ok && cfg_w.sel == lock_mask_pkg::SEL_LOCK_MASK) begin
      // reserved positions forced to zero on every write
      feature_lock_mask_q <= {{(`MASK_WIDTH-`MASK_USED){1'b0}}, cfg_w.data[`MASK_USED-1:0]};
    end
  end

  // refused pulse: a guarded write while the lock is set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_refused_q <= 1'b0;
    end else begin
      write_refused_q <= cfg_w.valid && !cfg_ok;
    end
  end

  // next high and low parts for the composer
  always_comb begin
    high_d = instance_high_part_q;
    low_d = instance_low_part_q;
    compose_start = 1'b0;
    if (cfg_ok && cfg_w.sel == lock_mask_pkg::SEL_INST_HIGH) begin
      high_d = cfg_w.data[`HIGH_WIDTH-1:0];
      compose_start = 1'b1;
    end
    if (cfg_ok && cfg_w.sel == lock_mask_pkg::SEL_INST_LOW) begin
      low_d = cfg_w.data[`LOW_WIDTH-1:0];
      compose_start = 1'b1;
    end
  end

  // high and low menu parts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      instance_high_part_q <= `HIGH_RESET;
      instance_low_part_q  <= `LOW_RESET;
    end else begin
      instance_high_part_q <= high_d;
      instance_low_part_q  <= low_d;
    end
  end

  // composer: one cycle from a part write to the new product
  instance_composer #(
    .HIGH_W (`HIGH_WIDTH),
    .LOW_W  (`LOW_WIDTH),
    .INST_W (`INST_WIDTH)
  ) u_composer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .start     (compose_start),
    .high_part (high_d),
    .low_part  (low_d),
    .done_q    (compose_done),
    .result_q  (compose_result)
  );

  // device instance: direct object write or composed parts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      device_instance_q <= `INST_RESET;
    end else if (cfg_ok && cfg_w.sel == lock_mask_pkg::SEL_INSTANCE) begin
      // direct write does not touch high and low parts
      device_instance_q <= cfg_w.data[`INST_WIDTH-1:0];
    end else if (compose_done) begin
      device_instance_q <= compose_result;
    end
  end

  // udp port setting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      udp_port_setting_q <= `UDP_RESET;
    end else if (cfg_ok && cfg_w.sel == lock_mask_pkg::SEL_UDP_PORT) begin
      udp_port_setting_q <= cfg_w.data[15:0];
    end
  end

  // hardware address tail setting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hw_address_tail_q <= `HW_TAIL_RESET;
    end else if (cfg_ok && cfg_w.sel == lock_mask_pkg::SEL_HW_TAIL) begin
      hw_address_tail_q <= cfg_w.data[15:0];
    end
  end

  // baud rate setting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      baud_setting_q <= `BAUD_RESET;
    end else if (cfg_ok && cfg_w.sel == lock_mask_pkg::SEL_BAUD) begin
      baud_setting_q <= cfg_w.data[7:0];
    end
  end

  // two-stage synchronisers; first stage read only by second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_meta_q     <= '0;
      key_sync_q     <= '0;
      contact_meta_q <= 1'b0;
      contact_sync_q <= 1'b0;
    end else begin
      key_meta_q     <= key_pins;
      key_sync_q     <= key_meta_q;
      contact_meta_q <= occupancy_contact;
      contact_sync_q <= contact_meta_q;
    end
  end

  // previous key level for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_prev_q <= '0;
    end else begin
      key_prev_q <= key_sync_q;
    end
  end

  // presses masked by bits zero to five
  always_comb begin
    key_rise  = key_sync_q & ~key_prev_q & ~feature_lock_mask_q[`KEY_COUNT-1:0];
    set_press = key_rise[`BIT_KEY_SET];
  end

  // key press pulses, one cycle each
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_press_q <= '0;
    end else begin
      key_press_q <= key_rise;
    end
  end

  // occupancy: contact when bit six clear, else network and set key
  // bit seven is left out on purpose; door contact has no effect
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      occupancy_cmd_q <= 1'b0;
    end else if (!feature_lock_mask_q[`BIT_CONTACT_OFF]) begin
      occupancy_cmd_q <= contact_sync_q;
    end else if (net_occupancy.valid) begin
      // network command wins over a set press in the same cycle
      occupancy_cmd_q <= net_occupancy.value;
    end else if (set_press) begin
      occupancy_cmd_q <= ~occupancy_cmd_q;
    end
  end

  // digital outputs follow algorithm or remote commands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      digital_outputs_q <= '0;
    end else if (feature_lock_mask_q[`BIT_REMOTE_DOUT]) begin
      digital_outputs_q <= remote_outputs;
    end else begin
      digital_outputs_q <= algo_outputs;
    end
  end

endmodule // feature_lock_bank
`default_nettype wire

// ### dv/net_supervisor.sv
// network supervisor model: lock mask and setting writes, occupancy commands
// assumes the bank samples its inputs on the rising clock edge
`timescale 1ns/1ns
`default_nettype none
module net_supervisor (
  // clock
  input  wire logic                     clk,
  // requests towards the bank
  output var  lock_mask_pkg::cfg_write_t net_write,
  output var  lock_mask_pkg::occ_cmd_t   net_occupancy
);
  initial begin
    net_write     = '0;
    net_occupancy = '0;
  end
  // one write, valid for one cycle; the data lines then flip so a late sample shows up
  task automatic send(input lock_mask_pkg::cfg_sel_t sel, input logic [31:0] data);
    @(negedge clk);
    net_write = '{1'b1, sel, data};
    @(negedge clk);
    net_write = '{1'b0, sel, ~data};
  endtask
  // one occupancy command pulse
  task automatic occupy(input logic v);
    @(negedge clk);
    net_occupancy = '{1'b1, v};
    @(negedge clk);
    net_occupancy = '{1'b0, ~v};
  endtask
  // a parameter change always opens the lock first
  task automatic reconfigure(input lock_mask_pkg::cfg_sel_t sel, input logic [31:0] data);
    send(lock_mask_pkg::SEL_LOCK_MASK, 32'h0000_0040);
    send(sel, data);
  endtask
endmodule // net_supervisor
`default_nettype wire

// ### dv/lock_mask_monitor.sv
// assertions on the ports of the lock mask bank
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module lock_mask_monitor #(parameter int DOUT_W = 4) (
  // clock, reset and writes
  input wire logic clk, sys_rst,
  input wire lock_mask_pkg::cfg_write_t menu_write, net_write,
  // pins and commands
  input wire logic [5:0] key_pins,
  input wire logic occupancy_contact,
  input wire lock_mask_pkg::occ_cmd_t net_occupancy,
  input wire logic [DOUT_W-1:0] algo_outputs, remote_outputs, digital_outputs_q,
  // observed settings
  input wire logic [15:0] feature_lock_mask_q, udp_port_setting_q, hw_address_tail_q,
  input wire logic [5:0] key_press_q,
  input wire logic occupancy_cmd_q, write_refused_q,
  input wire logic [21:0] device_instance_q,
  input wire logic [12:0] instance_high_part_q,
  input wire logic [9:0] instance_low_part_q,
  input wire logic [7:0] baud_setting_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire lock = feature_lock_mask_q[8];
  // guarded write taken this cycle, net side wins
  wire guarded = net_write.valid ? net_write.sel != lock_mask_pkg::SEL_LOCK_MASK
               : menu_write.valid && menu_write.sel != lock_mask_pkg::SEL_LOCK_MASK;
  sequence s_low_write;
    net_write.valid && net_write.sel == lock_mask_pkg::SEL_INST_LOW && !lock;
  endsequence
  sequence s_contact_mode;
    (!sys_rst && !feature_lock_mask_q[6])[*4];
  endsequence
  property p_reserved; feature_lock_mask_q[15:10] == 6'h00; endproperty
  property p_refuse; guarded && lock |=> write_refused_q; endproperty
  property p_udp; net_write.valid && net_write.sel == lock_mask_pkg::SEL_UDP_PORT && !lock
    |=> udp_port_setting_q == $past(net_write.data[15:0]); endproperty
  property p_compose; s_low_write |-> ##2
    device_instance_q == 22'($past(instance_high_part_q) * 1000 + $past(instance_low_part_q)); endproperty
  property p_keys; (key_press_q & $past(feature_lock_mask_q[5:0])) == 6'h00; endproperty
  property p_occ_net; net_occupancy.valid && feature_lock_mask_q[6]
    |=> occupancy_cmd_q == $past(net_occupancy.value); endproperty
  property p_contact; s_contact_mode |-> occupancy_cmd_q == $past(occupancy_contact, 3); endproperty
  property p_dout; !sys_rst |=> digital_outputs_q ==
    ($past(feature_lock_mask_q[9]) ? $past(remote_outputs) : $past(algo_outputs)); endproperty
  property p_reset; $fell(sys_rst) |-> feature_lock_mask_q == 16'h0040 &&
    device_instance_q == 22'h0927C1 && udp_port_setting_q == 16'hBAC0; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mask bits set");
  a_refuse: assert property (p_refuse) else $error("locked write not refused");
  a_udp: assert property (p_udp) else $error("udp write lost");
  a_compose: assert property (p_compose) else $error("instance not composed");
  a_keys: assert property (p_keys) else $error("locked key passed");
  a_occ_net: assert property (p_occ_net) else $error("network occupancy lost");
  a_contact: assert property (p_contact) else $error("contact not followed");
  a_dout: assert property (p_dout) else $error("output source wrong");
  a_reset: assert property (p_reset) else $error("reset value wrong");
endmodule // lock_mask_monitor
bind feature_lock_bank lock_mask_monitor #(.DOUT_W(DOUT_W)) lock_mask_monitor_i (.*);
`default_nettype wire

// ### dv/feature_lock_mask_and_net_id_tb.sv
// self-checking bench for the lock mask bank with a supervisor model
// assumes the bank and the supervisor model are compiled first
`timescale 1ns/1ns
`default_nettype none
module feature_lock_mask_and_net_id_tb;
  logic clk = 1'b0, sys_rst = 1'b1, occupancy_contact = 1'b0;
  lock_mask_pkg::cfg_write_t menu_write = '0, net_write;
  lock_mask_pkg::occ_cmd_t net_occupancy;
  logic [5:0] key_pins = '0, key_press_q;
  logic [3:0] algo_outputs = '0, remote_outputs = '0, digital_outputs_q;
  logic [15:0] feature_lock_mask_q, udp_port_setting_q, hw_address_tail_q;
  logic [21:0] device_instance_q;
  logic [12:0] instance_high_part_q, h;
  logic [9:0] instance_low_part_q, l;
  logic [7:0] baud_setting_q;
  logic occupancy_cmd_q, write_refused_q;
  logic [31:0] r;
  int num_errors = 0, checked = 0, cycles = 0, n;
  always #10 clk = ~clk;
  feature_lock_bank #(.DOUT_W(4)) feature_lock_bank_i (.*);
  net_supervisor net_supervisor_i (.clk(clk), .net_write(net_write), .net_occupancy(net_occupancy));
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [21:0] inst_of(input logic [12:0] hp, input logic [9:0] lp);
    return 22'(hp * 1000 + lp);
  endfunction
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic menu(input lock_mask_pkg::cfg_sel_t sel, input logic [31:0] d);
    @(negedge clk);
    menu_write = '{1'b1, sel, d};
    @(negedge clk);
    menu_write.valid = 1'b0;
  endtask
  // count key pulses over one press and release
  task automatic press(input int i);
    n = 0;
    @(negedge clk) key_pins[i] = 1'b1;
    repeat (8) begin
      @(negedge clk);
      n += int'(key_press_q[i] === 1'b1);
    end
    key_pins[i] = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic settle(input logic c);
    occupancy_contact = c;
    repeat (5) @(negedge clk);
  endtask
  initial begin
    void'($urandom(32'h7d17e13e));
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    chk("mask", 16'h0040, feature_lock_mask_q);
    chk("instance", 22'h0927C1, device_instance_q);
    chk("udp", 16'hBAC0, udp_port_setting_q);
    r = $urandom | 32'h0000_FD00;
    net_supervisor_i.send(lock_mask_pkg::SEL_LOCK_MASK, r);
    chk("mask", {6'h00, r[9:0]}, feature_lock_mask_q);
    menu(lock_mask_pkg::SEL_UDP_PORT, 32'h1234);
    chk("refused", 1, write_refused_q);
    net_supervisor_i.send(lock_mask_pkg::SEL_INSTANCE, 32'h5);
    chk("refused", 1, write_refused_q);
    chk("udp", 16'hBAC0, udp_port_setting_q);
    h = 13'($urandom_range(4193, 0));
    l = 10'($urandom_range(999, 0));
    net_supervisor_i.reconfigure(lock_mask_pkg::SEL_INST_HIGH, 32'(h));
    net_supervisor_i.send(lock_mask_pkg::SEL_INST_LOW, 32'(l));
    @(negedge clk);
    chk("instance", inst_of(h, l), device_instance_q);
    r = $urandom_range(4194302, 0);
    net_supervisor_i.send(lock_mask_pkg::SEL_INSTANCE, r);
    chk("instance", r[21:0], device_instance_q);
    menu(lock_mask_pkg::SEL_UDP_PORT, 32'hBAC1);
    chk("udp", 16'hBAC1, udp_port_setting_q);
    r = $urandom;
    menu(lock_mask_pkg::SEL_HW_TAIL, r);
    chk("hw tail", r[15:0], hw_address_tail_q);
    menu(lock_mask_pkg::SEL_BAUD, r);
    chk("baud", r[7:0], baud_setting_q);
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 32'h3F : (i == 1) ? 32'h0 : $urandom & 32'h3F;
      net_supervisor_i.send(lock_mask_pkg::SEL_LOCK_MASK, r | 32'h40);
      press(i);
      chk("key pulses", 32'(!r[i]), n);
    end
    net_supervisor_i.send(lock_mask_pkg::SEL_LOCK_MASK, 32'h0);
    settle(1'b1);
    chk("occupancy", 1, occupancy_cmd_q);
    settle(1'b0);
    chk("occupancy", 0, occupancy_cmd_q);
    net_supervisor_i.send(lock_mask_pkg::SEL_LOCK_MASK, 32'h80);
    settle(1'b1);
    chk("occupancy", 1, occupancy_cmd_q);
    net_supervisor_i.send(lock_mask_pkg::SEL_LOCK_MASK, 32'h40);
    settle(1'b0);
    chk("occupancy", 1, occupancy_cmd_q);
    net_supervisor_i.occupy(1'b0);
    chk("occupancy", 0, occupancy_cmd_q);
    for (int k = 0; k < 4; k++) begin
      net_supervisor_i.send(lock_mask_pkg::SEL_LOCK_MASK, k[0] ? 32'h240 : 32'h40);
      algo_outputs = 4'($urandom);
      remote_outputs = 4'($urandom);
      @(negedge clk);
      chk("outputs", k[0] ? remote_outputs : algo_outputs, digital_outputs_q);
    end
    complete_run();
  end
endmodule // feature_lock_mask_and_net_id_tb
`default_nettype wire
